/* File: core/dmc_mode_ctrl.sv */
// Four-channel DMA mode and control logic with a classic Wishbone slave
`timescale 1ns/10ps
`include "dmc_params.svh"

module dmc_mode_ctrl
  import dmc_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [31:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output      logic [31:0]                 wb_dat_o,
  output      logic                        wb_ack_o,
  input  wire logic [DMC_NCH-1:0]          hw_req,
  input  wire logic [DMC_NCH-1:0]          xfer_ack,
  input  wire logic                        nmi,
  output      logic [DMC_NCH-1:0]          xfer_req,
  output      logic [DMC_NCH-1:0]          chan_busy,
  output      logic [DMC_NCH-1:0]          done_flag,
  output      dmc_chan_cfg_s [DMC_NCH-1:0] chan_cfg
);

  localparam logic [31:0] MODE_IDX [DMC_NCH] =
    '{`DMC_MODE_IDX0, `DMC_MODE_IDX1, `DMC_MODE_IDX2, `DMC_MODE_IDX3};
  localparam logic [31:0] CTRL_IDX [DMC_NCH] =
    '{`DMC_CTRL_IDX0, `DMC_CTRL_IDX1, `DMC_CTRL_IDX2, `DMC_CTRL_IDX3};
  localparam logic [31:0] COUNT_IDX [DMC_NCH] =
    '{`DMC_COUNT_IDX0, `DMC_COUNT_IDX1, `DMC_COUNT_IDX2, `DMC_COUNT_IDX3};

  localparam dmc_state_s ST_RST = '{
    mode:      {DMC_NCH{`DMC_MODE_RST}},
    cnt:       {DMC_NCH{`DMC_COUNT_RST}},
    cnt_init:  {DMC_NCH{`DMC_COUNT_RST}},
    st:        {DMC_NCH{DMC_CH_IDLE}},
    en:        '0,
    keep:      '0,
    done:      '0,
    done_pend: '0,
    snap:      4'h0,
    nmi_d:     1'b0,
    ack:       1'b0,
    rdata:     32'h0000_0000
  };

  dmc_state_s         st_reg;
  dmc_state_s         st_next;

  logic               acc;
  logic               wr;
  logic [DMC_NCH-1:0] hit_mode;
  logic [DMC_NCH-1:0] hit_ctrl;
  logic [DMC_NCH-1:0] hit_cnt;
  logic               hit_snap;
  logic               hit_grp;
  logic [DMC_NCH-1:0] abort_w;
  logic [DMC_NCH-1:0] trig_w;
  logic [DMC_NCH-1:0] rd_ctrl;
  logic [DMC_NCH-1:0] cfg_ok;
  logic               nmi_rise;

  // Word index match; printed offsets are register indices
  function automatic logic idx_hit(input logic [31:0] adr, input logic [31:0] idx);
    return adr[31:2] == idx[29:0];
  endfunction : idx_hit

  // A request is taken once; ack in the next cycle ends it
  assign acc      = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign wr       = acc & wb_we_i;
  assign hit_snap = idx_hit(wb_adr_i, `DMC_SNAP_IDX);
  assign hit_grp  = idx_hit(wb_adr_i, `DMC_GROUP_IDX);
  assign nmi_rise = nmi & ~st_reg.nmi_d;

  // Per-channel decode, write strobes and setup legality
  for (genvar c = 0; c < DMC_NCH; c++) begin : g_chan
    assign hit_mode[c] = idx_hit(wb_adr_i, MODE_IDX[c]);
    assign hit_ctrl[c] = idx_hit(wb_adr_i, CTRL_IDX[c]);
    assign hit_cnt[c]  = idx_hit(wb_adr_i, COUNT_IDX[c]);
    assign abort_w[c]  = wr & hit_ctrl[c] & wb_sel_i[0]
                         & wb_dat_i[`DMC_CTRL_ABORT];
    assign trig_w[c]   = wr & hit_ctrl[c] & wb_sel_i[0]
                         & wb_dat_i[`DMC_CTRL_TRIG];
    assign rd_ctrl[c]  = acc & ~wb_we_i & hit_ctrl[c];
    // Prohibited codes keep the channel from starting; resume from suspend skips this check
    assign cfg_ok[c]   = ~st_reg.mode[c][`DMC_SIZE_HI]
                         & (st_reg.mode[c][`DMC_SRC_HI:`DMC_SRC_LO] != 2'h3)
                         & (st_reg.mode[c][`DMC_DST_HI:`DMC_DST_LO] != 2'h3)
                         & (st_reg.mode[c][`DMC_STYLE_HI:`DMC_STYLE_LO] != 2'h2);
    // Setup straight from the mode flops
    assign chan_cfg[c].size     = st_reg.mode[c][`DMC_SIZE_HI:`DMC_SIZE_LO];
    assign chan_cfg[c].src_step = st_reg.mode[c][`DMC_SRC_HI:`DMC_SRC_LO];
    assign chan_cfg[c].dst_step = st_reg.mode[c][`DMC_DST_HI:`DMC_DST_LO];
    assign chan_cfg[c].style    = st_reg.mode[c][`DMC_STYLE_HI:`DMC_STYLE_LO];
    assign chan_cfg[c].legal    = cfg_ok[c];
    assign xfer_req[c]  = st_reg.st[c] == DMC_CH_BUSY;
    assign chan_busy[c] = st_reg.st[c] != DMC_CH_IDLE;
  end

  assign done_flag = st_reg.done;
  assign wb_ack_o  = st_reg.ack;
  assign wb_dat_o  = st_reg.rdata;

  // Next state: bus access, software writes, then channel sequencing
  always_comb begin
    st_next           = st_reg;
    st_next.ack       = acc;
    st_next.rdata     = 32'h0000_0000;
    st_next.nmi_d     = nmi;
    st_next.done_pend = '0;

    // Read mux; unmapped addresses answer with zero
    if (acc && !wb_we_i) begin
      if (hit_snap) begin
        st_next.rdata = {28'h0, st_reg.snap};
      end else if (hit_grp) begin
        st_next.rdata = {28'h0, st_reg.en};
      end else begin
        for (int c = 0; c < DMC_NCH; c++) begin
          if (hit_mode[c]) begin
            st_next.rdata = {16'h0, st_reg.mode[c]};
          end else if (hit_cnt[c]) begin
            st_next.rdata = {16'h0, st_reg.cnt[c]};
          end else if (hit_ctrl[c]) begin
            // Abort and trigger always read zero
            st_next.rdata = {24'h0, st_reg.done[c], 3'h0, st_reg.keep[c],
                             2'h0, st_reg.en[c]};
          end
        end
      end
    end

    // Group register drives all four enables at once
    if (wr && hit_grp && wb_sel_i[0]) begin
      st_next.en = wb_dat_i[3:0];
    end

    // Per-channel software writes
    for (int c = 0; c < DMC_NCH; c++) begin
      if (wr && hit_mode[c]) begin
        // Reserved bits are not stored and read back zero
        if (wb_sel_i[0]) begin
          st_next.mode[c][7:0] = wb_dat_i[7:0] & 8'(`DMC_MODE_MASK);
        end
        if (wb_sel_i[1]) begin
          st_next.mode[c][15:8] = wb_dat_i[15:8] & 8'(`DMC_MODE_MASK >> 8);
        end
      end
      if (wr && hit_cnt[c]) begin
        if (wb_sel_i[0]) begin
          st_next.cnt[c][7:0]      = wb_dat_i[7:0];
          st_next.cnt_init[c][7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          st_next.cnt[c][15:8]      = wb_dat_i[15:8];
          st_next.cnt_init[c][15:8] = wb_dat_i[15:8];
        end
      end
      if (wr && hit_ctrl[c] && wb_sel_i[0]) begin
        st_next.en[c]   = wb_dat_i[`DMC_CTRL_EN];
        st_next.keep[c] = wb_dat_i[`DMC_CTRL_KEEP];
      end
    end

    // Channel sequencing
    for (int c = 0; c < DMC_NCH; c++) begin
      case (st_reg.st[c])
        DMC_CH_IDLE, DMC_CH_WAIT: begin
          // Hardware start ignores the flag under keep-enable only
          if (st_next.en[c] && cfg_ok[c] &&
              ((hw_req[c] && (!st_reg.done[c] || st_reg.keep[c])) ||
               (trig_w[c] && !st_reg.done[c]))) begin
            st_next.st[c] = DMC_CH_BUSY;
          end
        end
        DMC_CH_BUSY: begin
          if (xfer_ack[c]) begin
            if (st_reg.cnt[c] == 16'h0000) begin
              // Borrow: terminal count, count reloads for the next run
              st_next.cnt[c]       = st_reg.cnt_init[c];
              st_next.done_pend[c] = 1'b1;
              st_next.st[c]        = DMC_CH_IDLE;
              if (!st_reg.keep[c]) begin
                st_next.en[c] = 1'b0;
              end
            end else begin
              st_next.cnt[c] = st_reg.cnt[c] - 16'h0001;
              if (st_reg.mode[c][`DMC_STYLE_HI:`DMC_STYLE_LO] == DMC_XS_SINGLE) begin
                st_next.st[c] = DMC_CH_WAIT;
              end
            end
          end
        end
        DMC_CH_SUSP: begin
          // Re-enabling resumes where the run stopped
          if (st_next.en[c]) begin
            if (st_reg.mode[c][`DMC_STYLE_HI:`DMC_STYLE_LO] == DMC_XS_SINGLE) begin
              st_next.st[c] = DMC_CH_WAIT;
            end else begin
              st_next.st[c] = DMC_CH_BUSY;
            end
          end
        end
        default: begin
          st_next.st[c] = DMC_CH_IDLE;
        end
      endcase

      // Abort wins over sequencing; a final-cycle abort keeps its flag
      if (abort_w[c]) begin
        st_next.en[c]  = 1'b0;
        st_next.st[c]  = DMC_CH_IDLE;
        st_next.cnt[c] = st_reg.cnt_init[c];
      end

      // NMI suspends running channels and drops every enable
      if (nmi_rise) begin
        st_next.en[c] = 1'b0;
        if (st_next.st[c] == DMC_CH_BUSY || st_next.st[c] == DMC_CH_WAIT) begin
          st_next.st[c] = DMC_CH_SUSP;
        end
      end

      // Flag sets a cycle after the channel goes idle; set beats read-clear
      if (rd_ctrl[c]) begin
        st_next.done[c] = 1'b0;
      end
      if (st_reg.done_pend[c]) begin
        st_next.done[c] = 1'b1;
      end
    end

    // Snapshot holds the enables as they stood before the NMI
    if (nmi_rise) begin
      st_next.snap = st_reg.en;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : dmc_mode_ctrl

/* File: core/dmc_params.svh */
// Register map, field positions, reset values of the DMA mode/control block
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// Register indices; byte address is four times the index
`define DMC_MODE_IDX0   32'hfffff0d0
`define DMC_MODE_IDX1   32'hfffff0d2
`define DMC_MODE_IDX2   32'hfffff0d4
`define DMC_MODE_IDX3   32'hfffff0d6
`define DMC_CTRL_IDX0   32'hfffff0e0
`define DMC_CTRL_IDX1   32'hfffff0e2
`define DMC_CTRL_IDX2   32'hfffff0e4
`define DMC_CTRL_IDX3   32'hfffff0e6
`define DMC_COUNT_IDX0  32'hfffff0c0
`define DMC_COUNT_IDX1  32'hfffff0c2
`define DMC_COUNT_IDX2  32'hfffff0c4
`define DMC_COUNT_IDX3  32'hfffff0c6
`define DMC_SNAP_IDX    32'hfffff0f0
`define DMC_GROUP_IDX   32'hfffff0f2

// Mode register fields
`define DMC_SIZE_HI     15
`define DMC_SIZE_LO     14
`define DMC_SRC_HI      7
`define DMC_SRC_LO      6
`define DMC_DST_HI      5
`define DMC_DST_LO      4
`define DMC_STYLE_HI    3
`define DMC_STYLE_LO    2
`define DMC_MODE_MASK   16'hc0fc

// Control register fields
`define DMC_CTRL_DONE   7
`define DMC_CTRL_KEEP   3
`define DMC_CTRL_ABORT  2
`define DMC_CTRL_TRIG   1
`define DMC_CTRL_EN     0

// Reset values
`define DMC_MODE_RST    16'h0000
`define DMC_CTRL_RST    8'h00
`define DMC_COUNT_RST   16'h0000

`endif

/* File: core/dmc_pkg.sv */
// Types shared by the DMA mode/control block
package dmc_pkg;

  localparam int DMC_NCH = 4;

  typedef enum logic [1:0] {
    DMC_SZ_BYTE = 2'h0,
    DMC_SZ_HALF = 2'h1
  } dmc_size_e;

  typedef enum logic [1:0] {
    DMC_STEP_INC   = 2'h0,
    DMC_STEP_DEC   = 2'h1,
    DMC_STEP_FIXED = 2'h2
  } dmc_step_e;

  typedef enum logic [1:0] {
    DMC_XS_SINGLE = 2'h0,
    DMC_XS_STEP   = 2'h1,
    DMC_XS_BLOCK  = 2'h3
  } dmc_style_e;

  // Channel sequencer states, one-hot
  typedef enum logic [3:0] {
    DMC_CH_IDLE = 4'h1,
    DMC_CH_WAIT = 4'h2,
    DMC_CH_BUSY = 4'h4,
    DMC_CH_SUSP = 4'h8
  } dmc_chan_st_e;

  // Decoded channel setup handed to the bus side
  typedef struct packed {
    logic [1:0] size;
    logic [1:0] src_step;
    logic [1:0] dst_step;
    logic [1:0] style;
    logic       legal;
  } dmc_chan_cfg_s;

  // Whole state of the block
  typedef struct packed {
    logic [DMC_NCH-1:0][15:0]  mode;
    logic [DMC_NCH-1:0][15:0]  cnt;
    logic [DMC_NCH-1:0][15:0]  cnt_init;
    dmc_chan_st_e [DMC_NCH-1:0] st;
    logic [DMC_NCH-1:0]        en;
    logic [DMC_NCH-1:0]        keep;
    logic [DMC_NCH-1:0]        done;
    logic [DMC_NCH-1:0]        done_pend;
    logic [3:0]                snap;
    logic                      nmi_d;
    logic                      ack;
    logic [31:0]               rdata;
  } dmc_state_s;

endpackage : dmc_pkg

/* File: testbench/dmc_bus_model.sv */
// Bus-side model that finishes channel transfers
`timescale 1ns/10ps
module dmc_bus_model
  import dmc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic [DMC_NCH-1:0] xfer_req,
  input  wire logic [1:0]         slow,
  output      logic [DMC_NCH-1:0] xfer_ack
);
  logic [1:0] dly_reg [DMC_NCH];
  // One ack pulse per transfer; slow adds idle cycles to mimic a busy bus
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xfer_ack <= '0;
      dly_reg <= '{default: 2'h0};
    end else begin
      for (int i = 0; i < DMC_NCH; i++) begin
        xfer_ack[i] <= 1'b0;
        if (xfer_req[i] && !xfer_ack[i] && dly_reg[i] == 2'h0) begin
          xfer_ack[i] <= 1'b1;
          dly_reg[i] <= slow;
        end else if (xfer_req[i] && dly_reg[i] != 2'h0)
          dly_reg[i] <= dly_reg[i] - 2'h1;
      end
    end
  end
endmodule : dmc_bus_model

/* File: testbench/dmc_mode_ctrl_chk.sv */
// Assertion checker for the DMA mode/control block
`timescale 1ns/10ps
`include "dmc_params.svh"
module dmc_mode_ctrl_chk
  import dmc_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        nrst,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [31:0]                 wb_adr_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic [DMC_NCH-1:0]          xfer_ack,
  input wire logic                        nmi,
  input wire logic [DMC_NCH-1:0]          xfer_req,
  input wire logic [DMC_NCH-1:0]          chan_busy,
  input wire logic [DMC_NCH-1:0]          done_flag,
  input wire dmc_chan_cfg_s [DMC_NCH-1:0] chan_cfg
);
  logic rd0_reg;
  // High in the ack cycle of a read of channel 0 control
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rd0_reg <= 1'b0;
    else rd0_reg <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
                    && wb_adr_i == 32'(`DMC_CTRL_IDX0 << 2);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  AST_CTRL_WO: assert property (rd0_reg |-> wb_dat_o[6:4] == 3'h0 && wb_dat_o[2:1] == 2'h0)
    else $error("control reads nonzero in write-only bits");
  AST_DONE_RDCLR: assert property ($fell(done_flag[0]) |-> rd0_reg)
    else $error("done flag dropped without read");
  AST_DONE_ORDER: assert property ($rose(done_flag[0]) |-> !chan_busy[0] && !xfer_req[0])
    else $error("done flag set before channel stopped");
  AST_REQ_DROP: assert property ($fell(xfer_req[0]) |-> $past(xfer_ack[0]) || wb_ack_o || $past(nmi))
    else $error("request dropped with no cause");
  AST_NMI_HALT: assert property ($rose(nmi) |=> xfer_req == 4'h0)
    else $error("request survives nmi");
  AST_CFG_LEGAL: assert property (chan_cfg[0].legal == (!chan_cfg[0].size[1] &&
    chan_cfg[0].src_step != 2'h3 && chan_cfg[0].dst_step != 2'h3 && chan_cfg[0].style != 2'h2))
    else $error("legal flag wrong");
endmodule : dmc_mode_ctrl_chk
bind dmc_mode_ctrl dmc_mode_ctrl_chk u_dmc_mode_ctrl_chk (
  .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .xfer_ack(xfer_ack), .nmi(nmi), .xfer_req(xfer_req), .chan_busy(chan_busy),
  .done_flag(done_flag), .chan_cfg(chan_cfg));

/* File: testbench/tb_top.sv */
// Self-checking bench for the DMA mode/control block
`timescale 1ns/10ps
`include "dmc_params.svh"
module tb_top import dmc_pkg::*;;
  logic                        ref_clk, nrst, cyc, stb, we, nmi, ack;
  logic [31:0]                 adr, wdat, rdat, q, v, seed;
  logic [3:0]                  sel, hw_req, xfer_ack, xfer_req, chan_busy, done_flag;
  logic [1:0]                  slow;
  dmc_chan_cfg_s [DMC_NCH-1:0] chan_cfg;
  int                          bad_count, n_tests, n;
  int                          acks [4];
  dmc_mode_ctrl u_dmc_mode_ctrl (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .hw_req(hw_req), .xfer_ack(xfer_ack), .nmi(nmi),
    .xfer_req(xfer_req), .chan_busy(chan_busy), .done_flag(done_flag), .chan_cfg(chan_cfg));
  dmc_bus_model u_dmc_bus_model (.ref_clk(ref_clk), .nrst(nrst), .xfer_req(xfer_req),
    .slow(slow), .xfer_ack(xfer_ack));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ra(input logic [31:0] i, input int c);
    return (i + 32'(2 * c)) << 2;
  endfunction : ra
  function automatic logic lgl(input logic [15:0] m);
    return !m[15] && m[7:6] != 2'h3 && m[5:4] != 2'h3 && m[3:2] != 2'h2;
  endfunction : lgl
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic tmo();
    bad_count++;
    conclude();
  endtask : tmo
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Classic single cycle; ack, read data and release all belong to one rising edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) tmo();
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // Bounded wait: 0 done flag, 1 request, 2 channel idle
  task automatic wt(input int s, input int c);
    int k;
    logic [3:0] f;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
      f = (s == 0) ? done_flag : (s == 1) ? xfer_req : ~chan_busy;
    end while (f[c] !== 1'b1 && k < 500);
    if (k >= 500) tmo();
  endtask : wt
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Counts finished transfers; an ack outside a standing request is no transfer
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) acks[i] += int'(xfer_ack[i] & xfer_req[i]);
  end
  initial begin
    {nrst, cyc, stb, we, nmi, hw_req, slow, adr, wdat} = '0;
    {sel, bad_count, n_tests, seed} = {4'hf, 32'h0, 32'h0, 32'he449cf4c};
    acks = '{default: 0};
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    wb(1, 32'h10, 32'hffff);
    wb(0, 32'h10, 0);
    chk(q, 0);
    // Reset values, then random mode codes with reserved bits dropped
    for (int c = 0; c < 4; c++) begin
      wb(0, ra(`DMC_MODE_IDX0, c), 0);
      chk(q, 0);
      wb(0, ra(`DMC_CTRL_IDX0, c), 0);
      chk(q, 0);
      v = rnd();
      wb(1, ra(`DMC_MODE_IDX0, c), v);
      wb(0, ra(`DMC_MODE_IDX0, c), 0);
      chk(q, v & `DMC_MODE_MASK);
      chk(32'(chan_cfg[c]), {v[15:14], v[7:6], v[5:4], v[3:2], lgl(v[15:0])});
    end
    slow <= 2'h2;
    wb(1, ra(`DMC_MODE_IDX0, 0), 32'h000c);
    wb(1, ra(`DMC_COUNT_IDX0, 0), 32'h0001);
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h0003);
    wt(0, 0);
    chk(32'(acks[0]), 2);
    wb(0, ra(`DMC_CTRL_IDX0, 0), 0);
    chk(q, 32'h80);
    wb(0, ra(`DMC_CTRL_IDX0, 0), 0);
    chk(q, 0);
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h0002);
    repeat (4) @(negedge ref_clk);
    chk(chan_busy[0], 0);
    // Keep-enable: soft trigger refused with flag set, peripheral request accepted
    wb(1, ra(`DMC_MODE_IDX0, 0), 0);
    wb(1, ra(`DMC_COUNT_IDX0, 0), 0);
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h000b);
    wt(0, 0);
    n = acks[0];
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h000b);
    repeat (4) @(negedge ref_clk);
    chk(32'(acks[0]), 32'(n));
    @(posedge ref_clk);
    hw_req <= 4'h1;
    @(posedge ref_clk);
    hw_req <= 4'h0;
    repeat (10) @(negedge ref_clk);
    chk(32'(acks[0]), 32'(n + 1));
    chk(done_flag[0], 1);
    wb(0, ra(`DMC_CTRL_IDX0, 0), 0);
    chk(q, 32'h89);
    // Abort in mid-block
    wb(1, ra(`DMC_MODE_IDX0, 0), 32'h000c);
    wb(1, ra(`DMC_COUNT_IDX0, 0), 32'h0005);
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h0003);
    wt(1, 0);
    wb(1, ra(`DMC_CTRL_IDX0, 0), 32'h0004);
    @(negedge ref_clk);
    chk(chan_busy[0], 0);
    wb(0, ra(`DMC_CTRL_IDX0, 0), 0);
    chk(q, 0);
    // NMI snapshot, suspension and group restart
    slow <= 2'h3;
    for (int c = 1; c < 4; c++) begin
      wb(1, ra(`DMC_MODE_IDX0, c), 32'h000c);
      wb(1, ra(`DMC_COUNT_IDX0, c), 32'h0010);
      wb(1, ra(`DMC_CTRL_IDX0, c), (c < 3) ? 32'h3 : 32'h1);
    end
    @(posedge ref_clk);
    nmi <= 1'b1;
    wb(0, 32'(`DMC_SNAP_IDX << 2), 0);
    chk(q, 32'he);
    wb(0, ra(`DMC_CTRL_IDX0, 1), 0);
    chk(q, 0);
    wb(1, 32'(`DMC_GROUP_IDX << 2), 32'hf);
    nmi <= 1'b0;
    wb(0, ra(`DMC_CTRL_IDX0, 3), 0);
    chk(q, 32'h1);
    wt(2, 1);
    wt(2, 2);
    chk(32'(acks[1]), 32'h11);
    wb(1, 32'(`DMC_GROUP_IDX << 2), 0);
    wb(0, ra(`DMC_CTRL_IDX0, 3), 0);
    chk(q, 0);
    conclude();
  end
endmodule : tb_top
